// File: hw/tmr16_top.sv
// Top of the 16-bit timer: APB register file, up-counter, compare logic and pulse output.
// Assumes an APB master on i_core_clk and an asynchronous external count input pin.
//
// Operation
// - Period match with compare B raises interrupt
// - Interval/pulse modes count prescaler, software capture in any mode
// - External input clock selects event counting
// - Count each rising edge of external input
// - Programmable frequency, duty and output polarity
// - Either compare match alone inverts the toggle flop; both in one cycle cancel
// - Toggle flop drives the pulse output pin
// - Buffered compare A loads on B match
// - Zero compare code matches on overflow
// - Trigger enables gate each inversion source
`timescale 1ns/1ps
`default_nettype none

module tmr16_top (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_ext_count_in,
    output logic o_pulse_out_pin,
    output logic o_irq
);

    // ************************************************************
    // Reset synchroniser
    // ************************************************************
    // Reset takes hold at once but leaves two edges after the pin rises,
    // so every flop of the core comes out of reset in the same cycle.
    logic [1:0] rst_sync_r;
    logic rst_n;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    // ************************************************************
    // Helper functions
    // ************************************************************
    // Every offset that answers without a slave error.
    function automatic logic is_mapped(input logic [11:0] addr);
        case (addr)
            tmr16_pkg::ADDR_RUN,
            tmr16_pkg::ADDR_MODE,
            tmr16_pkg::ADDR_TOGGLE,
            tmr16_pkg::ADDR_CMP_A,
            tmr16_pkg::ADDR_CMP_B,
            tmr16_pkg::ADDR_CAP_A,
            tmr16_pkg::ADDR_IRQ_STATUS,
            tmr16_pkg::ADDR_IRQ_CLEAR,
            tmr16_pkg::ADDR_IRQ_ENABLE: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    // The next counter value equals the compare value; a zero code wraps,
    // so it matches exactly when the counter overflows.
    function automatic logic cmp_hit(input logic [15:0] cnt_inc, input logic [15:0] cmp);
        cmp_hit = (cnt_inc == cmp);
    endfunction : cmp_hit

    // Fields that read as constants are filled in here, so the state holds no copy of them.
    function automatic logic [31:0] read_mux(input logic [11:0] addr,
                                             input tmr16_pkg::tmr16_state_t s);
        case (addr)
            tmr16_pkg::ADDR_RUN: read_mux = {24'h000000, s.dbuf, 4'h0, s.prun, 1'b0, s.run};
            tmr16_pkg::ADDR_MODE: read_mux = {30'h00000000, s.clk_sel};
            tmr16_pkg::ADDR_TOGGLE: read_mux = {27'h0000000, s.toggle_ff, s.e1, s.e0, 2'b11};
            tmr16_pkg::ADDR_CMP_A: read_mux = {16'h0000, s.cmp_a};
            tmr16_pkg::ADDR_CMP_B: read_mux = {16'h0000, s.cmp_b};
            tmr16_pkg::ADDR_CAP_A: read_mux = {16'h0000, s.cap_a};
            tmr16_pkg::ADDR_IRQ_STATUS: read_mux = {30'h00000000, s.irq_status};
            tmr16_pkg::ADDR_IRQ_ENABLE: read_mux = {30'h00000000, s.irq_enable};
            default: read_mux = 32'h00000000;
        endcase
    endfunction : read_mux

    // ************************************************************
    // Prescaler
    // ************************************************************
    tmr16_pkg::tmr16_state_t s_r;
    tmr16_pkg::tmr16_state_t s_nxt;
    logic [2:0] psc_tick;

    // The prescaler run bit also gates external events, so clearing it freezes every source.
    tmr16_prescaler u_prescaler (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_run(s_r.prun),
        .o_tick(psc_tick)
    );

    // ************************************************************
    // Count source and compare matches
    // ************************************************************
    logic ext_rise;
    logic tick;
    logic [15:0] cnt_inc;
    logic match_a;
    logic match_b;
    logic flip_a;
    logic flip_b;
    logic flip;

    // Only the second synchroniser stage and its delayed copy are examined.
    assign ext_rise = s_r.ext_sync[1] & ~s_r.ext_prev;

    // A tick lasts one core cycle, so the counter moves at most once per cycle.
    always_comb begin
        case (s_r.clk_sel)
            tmr16_pkg::CLK_EXT_IN: tick = ext_rise & s_r.prun;
            tmr16_pkg::CLK_PSC_A: tick = psc_tick[0];
            tmr16_pkg::CLK_PSC_B: tick = psc_tick[1];
            tmr16_pkg::CLK_PSC_C: tick = psc_tick[2];
            default: tick = 1'b0;
        endcase
    end

    // ************************************************************
    // Compare matches
    // ************************************************************
    assign cnt_inc = s_r.up_counter + tmr16_pkg::CNT_ONE;
    assign match_a = s_r.run & tick & cmp_hit(cnt_inc, s_r.cmp_a);
    assign match_b = s_r.run & tick & cmp_hit(cnt_inc, s_r.cmp_b);
    assign flip_a = match_a & s_r.e0;
    assign flip_b = match_b & s_r.e1;
    // Both enabled matches in one cycle cancel, so the flop keeps its level then.
    assign flip = flip_a ^ flip_b;

    // ************************************************************
    // APB decode
    // ************************************************************
    logic apb_setup;
    logic apb_wr;
    logic [1:0] irq_clear;

    // Read data are taken in the setup cycle; writes land in the access cycle.
    assign apb_setup = i_psel & ~i_penable;
    assign apb_wr = i_psel & i_penable & i_pwrite & is_mapped(i_paddr);
    // Clear bits act only in the cycle that completes the write.
    always_comb begin
        if (apb_wr && i_paddr == tmr16_pkg::ADDR_IRQ_CLEAR) begin
            irq_clear = i_pwdata[1:0];
        end else begin
            irq_clear = 2'b00;
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.ext_sync = {s_r.ext_sync[0], i_ext_count_in};
        s_nxt.ext_prev = s_r.ext_sync[1];

        // ************************************************************
        // Up-counter
        // ************************************************************
        // Stopping the timer also resets the count.
        if (!s_r.run) begin
            s_nxt.up_counter = 16'h0000;
        end else if (match_b) begin
            s_nxt.up_counter = 16'h0000;
        end else if (tick) begin
            s_nxt.up_counter = cnt_inc;
        end

        // ************************************************************
        // Compare A buffer
        // ************************************************************
        // Loading only at the period boundary keeps a duty change from cutting a period short.
        if (match_b && s_r.dbuf) begin
            s_nxt.cmp_a = s_r.cmp_a_buf;
        end

        // ************************************************************
        // Toggle flop
        // ************************************************************
        if (flip) begin
            s_nxt.toggle_ff = ~s_r.toggle_ff;
        end

        // ************************************************************
        // Interrupt status
        // ************************************************************
        // A new event wins over a clear in the same cycle.
        s_nxt.irq_status[tmr16_pkg::IRQ_FIRST_BIT] =
            (s_r.irq_status[tmr16_pkg::IRQ_FIRST_BIT] & ~irq_clear[tmr16_pkg::IRQ_FIRST_BIT])
            | match_a;
        s_nxt.irq_status[tmr16_pkg::IRQ_PERIOD_BIT] =
            (s_r.irq_status[tmr16_pkg::IRQ_PERIOD_BIT] & ~irq_clear[tmr16_pkg::IRQ_PERIOD_BIT])
            | match_b;

        // ************************************************************
        // Register writes
        // ************************************************************
        // Writes to read-only offsets are accepted and change nothing.
        if (apb_wr) begin
            case (i_paddr)
                tmr16_pkg::ADDR_RUN: begin
                    s_nxt.run = i_pwdata[tmr16_pkg::RUN_CNT_BIT];
                    s_nxt.prun = i_pwdata[tmr16_pkg::RUN_PRUN_BIT];
                    s_nxt.dbuf = i_pwdata[tmr16_pkg::RUN_DBUF_BIT];
                end
                tmr16_pkg::ADDR_MODE: begin
                    s_nxt.clk_sel = tmr16_pkg::tmr16_clk_sel_t'(
                        i_pwdata[tmr16_pkg::MODE_CLK_LSB +: 2]);
                    // Software capture snapshots the running count.
                    if (i_pwdata[tmr16_pkg::MODE_SWCAP_BIT]) begin
                        s_nxt.cap_a = s_r.up_counter;
                    end
                end
                tmr16_pkg::ADDR_TOGGLE: begin
                    s_nxt.e0 = i_pwdata[tmr16_pkg::TOG_E0_BIT];
                    s_nxt.e1 = i_pwdata[tmr16_pkg::TOG_E1_BIT];
                    // A direct software command overrides a match in the same cycle.
                    case (tmr16_pkg::tmr16_ff_ctrl_t'(i_pwdata[tmr16_pkg::TOG_CTRL_LSB +: 2]))
                        tmr16_pkg::FF_INVERT: s_nxt.toggle_ff = ~s_r.toggle_ff;
                        tmr16_pkg::FF_SET: s_nxt.toggle_ff = 1'b1;
                        tmr16_pkg::FF_CLEAR: s_nxt.toggle_ff = 1'b0;
                        default: s_nxt.toggle_ff = s_nxt.toggle_ff;
                    endcase
                end
                // The buffer always follows the write, so enabling buffering starts from it.
                tmr16_pkg::ADDR_CMP_A: begin
                    s_nxt.cmp_a_buf = i_pwdata[15:0];
                    if (!s_r.dbuf) begin
                        s_nxt.cmp_a = i_pwdata[15:0];
                    end
                end
                tmr16_pkg::ADDR_CMP_B: begin
                    s_nxt.cmp_b = i_pwdata[15:0];
                end
                tmr16_pkg::ADDR_IRQ_ENABLE: begin
                    s_nxt.irq_enable = i_pwdata[1:0];
                end
                default: begin
                    s_nxt.irq_enable = s_nxt.irq_enable;
                end
            endcase
        end

        // ************************************************************
        // Read data
        // ************************************************************
        // Read data is captured in the setup cycle so the access phase needs no wait.
        if (apb_setup) begin
            s_nxt.prdata = read_mux(i_paddr, s_r);
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    // All core state leaves reset together on the synchronised release.
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= tmr16_pkg::STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Every access completes in its first access cycle.
    assign o_prdata = s_r.prdata;
    assign o_pready = i_psel & i_penable;
    assign o_pslverr = i_psel & i_penable & ~is_mapped(i_paddr);

    // ************************************************************
    // Pin and interrupt
    // ************************************************************
    // The pin shows the flop directly; polarity is chosen by setting or clearing it first.
    assign o_pulse_out_pin = s_r.toggle_ff;
    // The interrupt is a level that stays high until software clears or masks the source.
    assign o_irq = |(s_r.irq_status & s_r.irq_enable);

endmodule : tmr16_top
`default_nettype wire

// File: hw/tmr16_pkg.sv
// Constants, register map and state types for the 16-bit interval, event and pulse timer.
// Assumes a 32-bit APB master with a 12-bit byte address.
package tmr16_pkg;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_RUN = 12'h000;
    localparam logic [11:0] ADDR_MODE = 12'h004;
    localparam logic [11:0] ADDR_TOGGLE = 12'h008;
    localparam logic [11:0] ADDR_CMP_A = 12'h00C;
    localparam logic [11:0] ADDR_CMP_B = 12'h010;
    localparam logic [11:0] ADDR_CAP_A = 12'h014;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h018;
    localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h01C;
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h020;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int RUN_CNT_BIT = 0;
    localparam int RUN_PRUN_BIT = 2;
    localparam int RUN_DBUF_BIT = 7;
    localparam int MODE_CLK_LSB = 0;
    localparam int MODE_SWCAP_BIT = 6;
    localparam int TOG_CTRL_LSB = 0;
    localparam int TOG_E0_BIT = 2;
    localparam int TOG_E1_BIT = 3;
    localparam int IRQ_FIRST_BIT = 0;
    localparam int IRQ_PERIOD_BIT = 1;

    // ************************************************************
    // Prescaler taps and counter width
    // ************************************************************
    localparam int CNT_W = 16;
    localparam int PSC_W = 8;
    localparam logic [7:0] PSC_MASK_A = 8'h01;
    localparam logic [7:0] PSC_MASK_B = 8'h07;
    localparam logic [7:0] PSC_MASK_C = 8'h1F;
    localparam logic [15:0] CNT_ONE = 16'h0001;

    // ************************************************************
    // Encodings
    // ************************************************************
    typedef enum logic [1:0] {
        CLK_EXT_IN,
        CLK_PSC_A,
        CLK_PSC_B,
        CLK_PSC_C
    } tmr16_clk_sel_t;

    typedef enum logic [1:0] {
        FF_INVERT,
        FF_SET,
        FF_CLEAR,
        FF_KEEP
    } tmr16_ff_ctrl_t;

    // ************************************************************
    // State of the timer core
    // ************************************************************
    typedef struct packed {
        logic run;
        logic prun;
        logic dbuf;
        tmr16_clk_sel_t clk_sel;
        logic e0;
        logic e1;
        logic toggle_ff;
        logic [15:0] up_counter;
        logic [15:0] cmp_a;
        logic [15:0] cmp_a_buf;
        logic [15:0] cmp_b;
        logic [15:0] cap_a;
        logic [1:0] irq_status;
        logic [1:0] irq_enable;
        logic [1:0] ext_sync;
        logic ext_prev;
        logic [31:0] prdata;
    } tmr16_state_t;

    typedef struct packed {
        logic [7:0] cnt;
    } tmr16_psc_state_t;

    localparam tmr16_state_t STATE_RESET = '0;
    localparam tmr16_psc_state_t PSC_RESET = '0;

endpackage : tmr16_pkg

// File: hw/tmr16_prescaler.sv
// Prescaler, held at zero while stopped, that produces three single-cycle count ticks.
// Assumes an asynchronous active-low reset already released inside the core clock domain.
`timescale 1ns/1ps
`default_nettype none

module tmr16_prescaler (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_run,
    output logic [2:0] o_tick
);

    tmr16_pkg::tmr16_psc_state_t s_r;
    tmr16_pkg::tmr16_psc_state_t s_nxt;

    function automatic logic tap_hit(input logic [7:0] cnt, input logic [7:0] mask);
        tap_hit = ((cnt & mask) == mask);
    endfunction : tap_hit

    // ************************************************************
    // Divider
    // ************************************************************
    always_comb begin
        s_nxt = s_r;
        if (i_run) begin
            s_nxt.cnt = s_r.cnt + 8'h01;
        end else begin
            s_nxt.cnt = 8'h00;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_r <= tmr16_pkg::PSC_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // A stopped prescaler gives no ticks at all.
    assign o_tick[0] = i_run & tap_hit(s_r.cnt, tmr16_pkg::PSC_MASK_A);
    assign o_tick[1] = i_run & tap_hit(s_r.cnt, tmr16_pkg::PSC_MASK_B);
    assign o_tick[2] = i_run & tap_hit(s_r.cnt, tmr16_pkg::PSC_MASK_C);

endmodule : tmr16_prescaler
`default_nettype wire

// File: testbench/tmr16_ext_src.sv
// Model of the external event source that drives the count input pin.
// Assumes the timer samples the pin on i_core_clk rising edges.
`timescale 1ns/1ps
`default_nettype none

module tmr16_ext_src (
    input wire logic i_core_clk,
    output var logic o_pin
);
    initial o_pin = 1'b0;

    // Pulses stay at least two core cycles high and low so the synchroniser sees each one.
    task automatic pulses(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge i_core_clk);
            o_pin <= 1'b1;
            repeat (3) @(posedge i_core_clk);
            o_pin <= 1'b0;
            repeat (2) @(posedge i_core_clk);
        end
    endtask : pulses
endmodule : tmr16_ext_src
`default_nettype wire

// File: testbench/tmr16_top_asserts.sv
// Concurrent checks on the ports of the timer top.
// Assumes it is bound into tmr16_top.
`timescale 1ns/1ps
`default_nettype none

module tmr16_top_asserts (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_ext_count_in,
    input wire logic o_pulse_out_pin,
    input wire logic o_irq
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);

    sequence s_wr(logic [11:0] a);
        i_psel && i_penable && i_pwrite && i_paddr == a;
    endsequence
    sequence s_rd(logic [11:0] a);
        i_psel && i_penable && !i_pwrite && i_paddr == a;
    endsequence

    a_ready_access: assert property (i_psel && i_penable |-> o_pready)
        else $error("pready missing in access cycle");
    a_ready_idle: assert property (!i_penable |-> !o_pready && !o_pslverr)
        else $error("pready or pslverr outside access cycle");
    a_unmapped_zero: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h00000000)
        else $error("refused read returned data");
    a_irq_mask: assert property (
        s_wr(tmr16_pkg::ADDR_IRQ_ENABLE) ##0 i_pwdata[1:0] == 2'h0 |=> !o_irq [*2])
        else $error("irq high with all sources masked");
    a_ff_set: assert property (
        s_wr(tmr16_pkg::ADDR_TOGGLE) ##0 i_pwdata[1:0] == 2'h1 |=> o_pulse_out_pin)
        else $error("pulse pin not set");
    a_ff_clear: assert property (
        s_wr(tmr16_pkg::ADDR_TOGGLE) ##0 i_pwdata[1:0] == 2'h2 |=> !o_pulse_out_pin)
        else $error("pulse pin not cleared");
    a_ff_invert: assert property (
        s_wr(tmr16_pkg::ADDR_TOGGLE) ##0 i_pwdata[1:0] == 2'h0
        |=> o_pulse_out_pin != $past(o_pulse_out_pin))
        else $error("pulse pin not inverted");
    a_toggle_read: assert property (s_rd(tmr16_pkg::ADDR_TOGGLE) |-> o_prdata[1:0] == 2'h3)
        else $error("toggle command field not read as ones");
    a_clear_read: assert property (s_rd(tmr16_pkg::ADDR_IRQ_CLEAR) |-> o_prdata == 32'h00000000)
        else $error("clear register read not zero");
endmodule : tmr16_top_asserts

bind tmr16_top tmr16_top_asserts u_tmr16_top_asserts (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_ext_count_in(i_ext_count_in),
    .o_pulse_out_pin(o_pulse_out_pin), .o_irq(o_irq));
`default_nettype wire

// File: testbench/tb_tmr16_top.sv
// Self-checking testbench for the timer top: registers, pulse, interrupt, buffer and events.
// Assumes the event source model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none

module tb_tmr16_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic [31:0] rq;
    logic pready, pslverr, ext_in, pin, irq, rerr;
    int fails = 0;
    int checks_done = 0;
    int cyc = 0;
    int hi, lo, n;

    always #5 clk = ~clk;

    tmr16_top u_tmr16_top (.i_core_clk(clk), .i_resetn(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_ext_count_in(ext_in), .o_pulse_out_pin(pin), .o_irq(irq));
    tmr16_ext_src u_tmr16_ext_src (.i_core_clk(clk), .o_pin(ext_in));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rq = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rq, exp);
    endtask : rd

    task automatic chk_irq(input logic exp);
        @(negedge clk);
        chk({31'h00000000, irq}, {31'h00000000, exp});
    endtask : chk_irq

    // Measures one high phase and the low phase after it, in core cycles.
    task automatic meas();
        hi = 0;
        lo = 0;
        wait (pin === 1'b0);
        wait (pin === 1'b1);
        @(negedge clk);
        while (pin === 1'b1) begin
            hi++;
            @(negedge clk);
        end
        while (pin === 1'b0) begin
            lo++;
            @(negedge clk);
        end
    endtask : meas

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs();
        for (int i = 0; i < 9; i++) begin
            rd(12'(i * 4), (i == 2) ? 32'h00000003 : 32'h00000000);
        end
        wr(12'h040, 32'hFFFFFFFF);
        chk({31'h00000000, rerr}, 32'h00000001);
        rd(12'h040, 32'h00000000);
        chk({31'h00000000, rerr}, 32'h00000001);
        $display("register test done");
    endtask : t_regs

    task automatic t_pulse();
        wr(tmr16_pkg::ADDR_CMP_A, 32'h00000001);
        wr(tmr16_pkg::ADDR_CMP_B, 32'h00000004);
        wr(tmr16_pkg::ADDR_MODE, 32'h00000001);
        wr(tmr16_pkg::ADDR_TOGGLE, 32'h0000000E);
        wr(tmr16_pkg::ADDR_RUN, 32'h00000005);
        meas();
        chk(32'(hi), 32'h00000006);
        chk(32'(lo), 32'h00000002);
        wr(tmr16_pkg::ADDR_TOGGLE, 32'h0000000B);
        meas();
        chk(32'(hi), 32'h00000008);
        chk(32'(lo), 32'h00000008);
        wr(tmr16_pkg::ADDR_RUN, 32'h00000000);
        wr(tmr16_pkg::ADDR_TOGGLE, 32'h0000000D);
        wr(tmr16_pkg::ADDR_RUN, 32'h00000005);
        meas();
        chk(32'(hi), 32'h00000002);
        chk(32'(lo), 32'h00000006);
        $display("pulse test done");
    endtask : t_pulse

    task automatic t_irq();
        wr(tmr16_pkg::ADDR_IRQ_ENABLE, 32'h00000002);
        chk_irq(1'b1);
        rd(tmr16_pkg::ADDR_IRQ_STATUS, 32'h00000003);
        wr(tmr16_pkg::ADDR_IRQ_ENABLE, 32'h00000000);
        chk_irq(1'b0);
        wr(tmr16_pkg::ADDR_IRQ_ENABLE, 32'h00000002);
        wr(tmr16_pkg::ADDR_RUN, 32'h00000000);
        wr(tmr16_pkg::ADDR_IRQ_CLEAR, 32'h00000003);
        rd(tmr16_pkg::ADDR_IRQ_STATUS, 32'h00000000);
        chk_irq(1'b0);
        wr(tmr16_pkg::ADDR_RUN, 32'h00000005);
        n = 0;
        while (irq !== 1'b1 && n < 12) begin
            @(negedge clk);
            n++;
        end
        chk_irq(1'b1);
        rd(tmr16_pkg::ADDR_IRQ_STATUS, 32'h00000003);
        $display("interrupt test done");
    endtask : t_irq

    task automatic t_dbuf();
        wr(tmr16_pkg::ADDR_RUN, 32'h00000080);
        wr(tmr16_pkg::ADDR_TOGGLE, 32'h00000000);
        wr(tmr16_pkg::ADDR_CMP_A, 32'h00000002);
        rd(tmr16_pkg::ADDR_CMP_A, 32'h00000001);
        wr(tmr16_pkg::ADDR_RUN, 32'h00000085);
        repeat (12) @(posedge clk);
        rd(tmr16_pkg::ADDR_CMP_A, 32'h00000002);
        $display("double buffer test done");
    endtask : t_dbuf

    task automatic t_event();
        wr(tmr16_pkg::ADDR_RUN, 32'h00000000);
        wr(tmr16_pkg::ADDR_MODE, 32'h00000000);
        wr(tmr16_pkg::ADDR_CMP_B, 32'h00000000);
        wr(tmr16_pkg::ADDR_RUN, 32'h00000005);
        u_tmr16_ext_src.pulses(5);
        repeat (4) @(posedge clk);
        wr(tmr16_pkg::ADDR_MODE, 32'h00000040);
        rd(tmr16_pkg::ADDR_CAP_A, 32'h00000005);
        $display("event test done");
    endtask : t_event

    task automatic t_psc();
        wr(tmr16_pkg::ADDR_CMP_A, 32'h00000001);
        wr(tmr16_pkg::ADDR_CMP_B, 32'h00000002);
        for (int m = 2; m < 4; m++) begin
            wr(tmr16_pkg::ADDR_RUN, 32'h00000000);
            wr(tmr16_pkg::ADDR_MODE, 32'(m));
            wr(tmr16_pkg::ADDR_TOGGLE, 32'h0000000E);
            wr(tmr16_pkg::ADDR_RUN, 32'h00000005);
            meas();
            chk(32'(hi), (m == 2) ? 32'h00000008 : 32'h00000020);
            chk(32'(lo), (m == 2) ? 32'h00000008 : 32'h00000020);
        end
        $display("prescaler test done");
    endtask : t_psc

    task automatic t_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk({31'h00000000, pin}, 32'h00000000);
        chk({31'h00000000, irq}, 32'h00000000);
        rd(tmr16_pkg::ADDR_RUN, 32'h00000000);
        rd(tmr16_pkg::ADDR_CMP_B, 32'h00000000);
        $display("reset test done");
    endtask : t_reset

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            test_done();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_pulse();
        t_irq();
        t_dbuf();
        t_event();
        t_psc();
        t_reset();
        test_done();
    end
endmodule : tb_tmr16_top
`default_nettype wire
